// ===== verilog/wakeup_timer_unit.sv
// wake-up timer unit with third timer count readback
`timescale 1ns/1ps
module wakeup_timer_unit (
   input  wire logic       i_clk,
   input  wire logic       i_arst_n,
   input  wire logic [6:0] i_reg_addr,
   input  wire logic       i_reg_wr,
   input  wire logic [7:0] i_reg_wdata,
   output logic      [7:0] o_reg_rdata,
   input  wire logic       i_slow_oscillator,
   input  wire logic [15:0] i_timer3_count,
   input  wire logic       i_timer3_underflow,
   input  wire logic       i_card_detected,
   input  wire logic       i_detect_done,
   output logic            o_trim_start,
   output logic            o_card_detect_start,
   output logic            o_rf_field_on,
   output logic            o_timer3_start,
   output logic            o_wake_up,
   output logic            o_power_down,
   output logic            o_card_irq,
   output logic            o_wake_underflow_flag
);
   // ==========================================================
   // state
   typedef struct packed {
      logic [2:0]  osc_sync;
      logic        running;
      logic        auto_trim;
      logic        auto_card;
      logic        auto_restart;
      logic        auto_wake;
      logic [1:0]  clk_sel;
      logic [7:0]  reload_high;
      logic [7:0]  reload_low;
      logic [15:0] count;
      logic [4:0]  prescale;
      wake_timer_pkg::det_state_e det;
      logic        trim_start;
      logic        det_start;
      logic        t3_start;
      logic        wake_up;
      logic        power_down;
      logic        card_irq;
      logic        uflow_flag;
      logic [7:0]  rdata;
      logic        field_on;
   } state_s;

   state_s state_r;
   state_s state_nxt;

   // ==========================================================
   // prescaler mask per clock select code
   function automatic logic [4:0] div_mask(input logic [1:0] sel);
      unique case (sel)
         wake_timer_pkg::CLK_DIV1:  div_mask = wake_timer_pkg::PRE_ZERO;
         wake_timer_pkg::CLK_DIV8:  div_mask = wake_timer_pkg::PRE_MASK8;
         wake_timer_pkg::CLK_DIV16: div_mask = wake_timer_pkg::PRE_MASK16;
         wake_timer_pkg::CLK_DIV32: div_mask = wake_timer_pkg::PRE_MASK32;
      endcase
   endfunction

   // ==========================================================
   // start event: control write with permit and running set
   function automatic logic start_write(input logic       wr,
                                        input logic [6:0] addr,
                                        input logic [7:0] data);
      start_write = wr
                    && addr == wake_timer_pkg::ADDR_WAKE_CONTROL
                    && data[wake_timer_pkg::BIT_CHANGE_PERMIT]
                    && data[wake_timer_pkg::BIT_RUNNING];
   endfunction

   logic        osc_rise;
   logic        tick;
   logic        underflow;
   logic [15:0] reload_value;
   logic [7:0]  control_view;
   logic        start_event;

   // ==========================================================
   // next state
   always_comb begin
      state_nxt = state_r;

      // ==========================================================
      // slow oscillator: two-flop synchroniser, then edge
      state_nxt.osc_sync = {state_r.osc_sync[1:0], i_slow_oscillator};
      osc_rise = state_r.osc_sync[1] & ~state_r.osc_sync[2];
      reload_value = {state_r.reload_high, state_r.reload_low};
      state_nxt.trim_start = 1'b0;
      state_nxt.det_start  = 1'b0;
      state_nxt.t3_start   = 1'b0;
      state_nxt.wake_up    = 1'b0;
      state_nxt.card_irq   = 1'b0;
      tick      = 1'b0;
      underflow = 1'b0;
      start_event = start_write(i_reg_wr, i_reg_addr, i_reg_wdata);

      // ==========================================================
      // prescaler and counter
      if (state_r.running && osc_rise) begin
         if ((state_r.prescale & div_mask(state_r.clk_sel))
             == div_mask(state_r.clk_sel)) begin
            state_nxt.prescale = wake_timer_pkg::PRE_ZERO;
            tick = 1'b1;
         end else begin
            state_nxt.prescale = state_r.prescale
                                 + wake_timer_pkg::PRE_STEP;
         end
      end
      if (tick) begin
         if (state_r.count == wake_timer_pkg::COUNT_ZERO) begin
            underflow = 1'b1;
            if (state_r.auto_restart || state_r.auto_card) begin
               state_nxt.count = reload_value;
            end else begin
               state_nxt.running = 1'b0;
            end
         end else begin
            state_nxt.count = state_r.count
                              - wake_timer_pkg::COUNT_STEP;
         end
      end

      // ==========================================================
      // underflow actions
      if (underflow) begin
         state_nxt.trim_start = state_r.auto_trim;
         state_nxt.wake_up    = state_r.auto_wake;
         if (state_r.auto_card && state_r.det == wake_timer_pkg::DET_IDLE)
         begin
            state_nxt.det       = wake_timer_pkg::DET_FIELD;
            state_nxt.det_start = 1'b1;
            state_nxt.t3_start  = 1'b1;
            state_nxt.power_down = 1'b0;
         end
      end

      // ==========================================================
      // card detection sequence
      unique case (state_r.det)
         wake_timer_pkg::DET_IDLE: begin
         end
         wake_timer_pkg::DET_FIELD: begin
            if (i_timer3_underflow) begin
               state_nxt.det = wake_timer_pkg::DET_WAIT;
            end
         end
         wake_timer_pkg::DET_WAIT: begin
            if (i_detect_done) begin
               state_nxt.det = wake_timer_pkg::DET_IDLE;
               if (i_card_detected) begin
                  state_nxt.card_irq = 1'b1;
               end else begin
                  state_nxt.power_down = state_r.auto_wake;
               end
            end
         end
         default: begin
            state_nxt.det = wake_timer_pkg::DET_IDLE;
         end
      endcase

      // ==========================================================
      // register writes
      if (i_reg_wr) begin
         unique case (i_reg_addr)
            wake_timer_pkg::ADDR_WAKE_CONTROL: begin
               state_nxt.auto_trim =
                  i_reg_wdata[wake_timer_pkg::BIT_AUTO_TRIM];
               state_nxt.auto_card =
                  i_reg_wdata[wake_timer_pkg::BIT_AUTO_CARD];
               state_nxt.auto_restart =
                  i_reg_wdata[wake_timer_pkg::BIT_AUTO_RESTART];
               state_nxt.auto_wake =
                  i_reg_wdata[wake_timer_pkg::BIT_AUTO_WAKE];
               state_nxt.clk_sel = i_reg_wdata[wake_timer_pkg::CLKSEL_HI:
                                               wake_timer_pkg::CLKSEL_LO];
               if (i_reg_wdata[wake_timer_pkg::BIT_CHANGE_PERMIT]) begin
                  state_nxt.running =
                     i_reg_wdata[wake_timer_pkg::BIT_RUNNING];
                  if (start_event) begin
                     state_nxt.count    = reload_value;
                     state_nxt.prescale = wake_timer_pkg::PRE_ZERO;
                  end
               end
            end
            wake_timer_pkg::ADDR_WAKE_RELOAD_HIGH:
               state_nxt.reload_high = i_reg_wdata;
            wake_timer_pkg::ADDR_WAKE_RELOAD_LOW:
               state_nxt.reload_low = i_reg_wdata;
            default: begin
            end
         endcase
      end

      // ==========================================================
      // sticky flag: set wins over clear
      if (start_event) begin
         state_nxt.uflow_flag = 1'b0;
      end
      if (underflow) begin
         state_nxt.uflow_flag = 1'b1;
      end

      // ==========================================================
      // read data
      control_view = {state_r.running, 1'b0, state_r.auto_trim,
                      state_r.auto_card, state_r.auto_restart,
                      state_r.auto_wake, state_r.clk_sel};
      unique case (i_reg_addr)
         wake_timer_pkg::ADDR_T3_COUNT_HIGH:
            state_nxt.rdata = i_timer3_count[15:8];
         wake_timer_pkg::ADDR_T3_COUNT_LOW:
            state_nxt.rdata = i_timer3_count[7:0];
         wake_timer_pkg::ADDR_WAKE_CONTROL:
            state_nxt.rdata = control_view;
         wake_timer_pkg::ADDR_WAKE_RELOAD_HIGH:
            state_nxt.rdata = state_r.reload_high;
         wake_timer_pkg::ADDR_WAKE_RELOAD_LOW:
            state_nxt.rdata = state_r.reload_low;
         wake_timer_pkg::ADDR_WAKE_COUNT_HIGH:
            state_nxt.rdata = state_r.count[15:8];
         wake_timer_pkg::ADDR_WAKE_COUNT_LOW:
            state_nxt.rdata = state_r.count[7:0];
         default:
            state_nxt.rdata = 8'h00;
      endcase

      // ==========================================================
      // field on while waiting for the field timer
      state_nxt.field_on =
         (state_nxt.det == wake_timer_pkg::DET_FIELD);
   end

   // ==========================================================
   // registers
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_r.osc_sync     <= '0;
         state_r.running      <=
            wake_timer_pkg::CONTROL_RESET[wake_timer_pkg::BIT_RUNNING];
         state_r.auto_trim    <=
            wake_timer_pkg::CONTROL_RESET[wake_timer_pkg::BIT_AUTO_TRIM];
         state_r.auto_card    <=
            wake_timer_pkg::CONTROL_RESET[wake_timer_pkg::BIT_AUTO_CARD];
         state_r.auto_restart <=
            wake_timer_pkg::CONTROL_RESET[wake_timer_pkg::BIT_AUTO_RESTART];
         state_r.auto_wake    <=
            wake_timer_pkg::CONTROL_RESET[wake_timer_pkg::BIT_AUTO_WAKE];
         state_r.clk_sel      <=
            wake_timer_pkg::CONTROL_RESET[wake_timer_pkg::CLKSEL_HI:
                                          wake_timer_pkg::CLKSEL_LO];
         state_r.reload_high  <= wake_timer_pkg::RELOAD_RESET;
         state_r.reload_low   <= wake_timer_pkg::RELOAD_RESET;
         state_r.count        <= wake_timer_pkg::COUNT_RESET;
         state_r.prescale     <= wake_timer_pkg::PRE_ZERO;
         state_r.det          <= wake_timer_pkg::DET_IDLE;
         state_r.trim_start   <= '0;
         state_r.det_start    <= '0;
         state_r.t3_start     <= '0;
         state_r.wake_up      <= '0;
         state_r.power_down   <= '0;
         state_r.card_irq     <= '0;
         state_r.uflow_flag   <= '0;
         state_r.rdata        <= '0;
         state_r.field_on     <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ==========================================================
   // outputs
   assign o_reg_rdata           = state_r.rdata;
   assign o_trim_start          = state_r.trim_start;
   assign o_card_detect_start   = state_r.det_start;
   assign o_rf_field_on         = state_r.field_on;
   assign o_timer3_start        = state_r.t3_start;
   assign o_wake_up             = state_r.wake_up;
   assign o_power_down          = state_r.power_down;
   assign o_card_irq            = state_r.card_irq;
   assign o_wake_underflow_flag = state_r.uflow_flag;
endmodule

// ===== verilog/wake_timer_pkg.sv
// constants for the wake-up timer unit
package wake_timer_pkg;
   // ==========================================================
   // register addresses
   localparam logic [6:0] ADDR_T3_COUNT_HIGH     = 7'h21;
   localparam logic [6:0] ADDR_T3_COUNT_LOW      = 7'h22;
   localparam logic [6:0] ADDR_WAKE_CONTROL      = 7'h23;
   localparam logic [6:0] ADDR_WAKE_RELOAD_HIGH  = 7'h24;
   localparam logic [6:0] ADDR_WAKE_RELOAD_LOW   = 7'h25;
   localparam logic [6:0] ADDR_WAKE_COUNT_HIGH   = 7'h26;
   localparam logic [6:0] ADDR_WAKE_COUNT_LOW    = 7'h27;
   // ==========================================================
   // control register fields
   localparam int BIT_RUNNING       = 7;
   localparam int BIT_CHANGE_PERMIT = 6;
   localparam int BIT_AUTO_TRIM     = 5;
   localparam int BIT_AUTO_CARD     = 4;
   localparam int BIT_AUTO_RESTART  = 3;
   localparam int BIT_AUTO_WAKE     = 2;
   localparam int CLKSEL_HI         = 1;
   localparam int CLKSEL_LO         = 0;
   // ==========================================================
   // reset values and counter constants
   localparam logic [7:0]  CONTROL_RESET = 8'h00;
   localparam logic [7:0]  RELOAD_RESET  = 8'h00;
   localparam logic [15:0] COUNT_RESET   = 16'h0000;
   localparam logic [15:0] COUNT_ZERO    = 16'h0000;
   localparam logic [15:0] COUNT_STEP    = 16'h0001;
   // ==========================================================
   // slow oscillator prescaler
   localparam logic [1:0] CLK_DIV1  = 2'h0;
   localparam logic [1:0] CLK_DIV8  = 2'h1;
   localparam logic [1:0] CLK_DIV16 = 2'h2;
   localparam logic [1:0] CLK_DIV32 = 2'h3;
   localparam logic [4:0] PRE_MASK8  = 5'h07;
   localparam logic [4:0] PRE_MASK16 = 5'h0F;
   localparam logic [4:0] PRE_MASK32 = 5'h1F;
   localparam logic [4:0] PRE_ZERO   = 5'h00;
   localparam logic [4:0] PRE_STEP   = 5'h01;
   // ==========================================================
   // card detection sequence states
   typedef enum logic [1:0] {
      DET_IDLE,
      DET_FIELD,
      DET_WAIT
   } det_state_e;
endpackage

// ===== test/wakeup_timer_unit_checker.sv
// assertion checker for the wake-up timer unit
`timescale 1ns/1ps
module wakeup_timer_unit_checker (
   input wire logic        i_clk,
   input wire logic        i_arst_n,
   input wire logic [6:0]  i_reg_addr,
   input wire logic        i_reg_wr,
   input wire logic [7:0]  i_reg_wdata,
   input wire logic [7:0]  o_reg_rdata,
   input wire logic [15:0] i_timer3_count,
   input wire logic        i_timer3_underflow,
   input wire logic        i_card_detected,
   input wire logic        i_detect_done,
   input wire logic        o_rf_field_on,
   input wire logic        o_power_down,
   input wire logic        o_card_irq,
   input wire logic        o_wake_underflow_flag
);
   // ==========================================================
   // properties
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   AST_T3_HIGH: assert property (
      $past(i_arst_n) && $past(i_reg_addr) == 7'h21
      |-> o_reg_rdata == $past(i_timer3_count[15:8])) else $error("t3 high");
   AST_T3_LOW: assert property (
      $past(i_arst_n) && $past(i_reg_addr) == 7'h22
      |-> o_reg_rdata == $past(i_timer3_count[7:0])) else $error("t3 low");
   AST_UNMAPPED: assert property (
      $past(i_arst_n)
      && ($past(i_reg_addr) < 7'h21 || $past(i_reg_addr) > 7'h27)
      |-> o_reg_rdata == 8'h00) else $error("unmapped read");
   AST_FLAG_CLEAR: assert property (
      $fell(o_wake_underflow_flag) |-> $past(i_reg_wr && i_reg_addr == 7'h23
      && i_reg_wdata[7:6] == 2'b11)) else $error("flag cleared");
   AST_PD_SET: assert property (
      $rose(o_power_down) |-> $past(i_detect_done && !i_card_detected))
      else $error("power down set");
   AST_IRQ: assert property (
      o_card_irq |-> $past(i_detect_done && i_card_detected))
      else $error("card irq");
   AST_FIELD_OFF: assert property (
      o_rf_field_on && i_timer3_underflow |=> !o_rf_field_on)
      else $error("field off");
   AST_PD_IRQ: assert property (
      o_card_irq |-> !o_power_down) else $error("irq with power down");
endmodule
bind wakeup_timer_unit wakeup_timer_unit_checker u_chk (
   .i_clk                 (i_clk),
   .i_arst_n              (i_arst_n),
   .i_reg_addr            (i_reg_addr),
   .i_reg_wr              (i_reg_wr),
   .i_reg_wdata           (i_reg_wdata),
   .o_reg_rdata           (o_reg_rdata),
   .i_timer3_count        (i_timer3_count),
   .i_timer3_underflow    (i_timer3_underflow),
   .i_card_detected       (i_card_detected),
   .i_detect_done         (i_detect_done),
   .o_rf_field_on         (o_rf_field_on),
   .o_power_down          (o_power_down),
   .o_card_irq            (o_card_irq),
   .o_wake_underflow_flag (o_wake_underflow_flag)
);

// ===== test/wakeup_timer_unit_tb_top.sv
// self-checking testbench for the wake-up timer unit
`timescale 1ns/1ps
module wakeup_timer_unit_tb_top;
   // ==========================================================
   // signals and model
   logic        i_clk = 1'b0;
   logic        i_arst_n = 1'b0;
   logic        i_reg_wr = 1'b0;
   logic        i_slow_oscillator = 1'b0;
   logic        i_timer3_underflow = 1'b0;
   logic        i_card_detected = 1'b0;
   logic        i_detect_done = 1'b0;
   logic [6:0]  i_reg_addr = 7'h00;
   logic [7:0]  i_reg_wdata = 8'h00, o_reg_rdata;
   logic [15:0] i_timer3_count = 16'h0000;
   logic o_trim_start, o_card_detect_start, o_rf_field_on, o_timer3_start;
   logic o_wake_up, o_power_down, o_card_irq, o_wake_underflow_flag;
   logic [7:0]  md[4] = '{8'h00, 8'h20, 8'h04, 8'h08};
   int dv[4] = '{1, 8, 16, 32};
   int err_count = 0, n_checks = 0, m_cnt = 0, m_rel = 0, m_run = 0, m_ctl = 0;
   int m_pre = 0, m_flag = 0, m_trim = 0, m_wake = 0, trim_n = 0, wake_n = 0;
   int irq_n = 0, det_n = 0, t3s_n = 0, m_det = 0, r, cs;
   wakeup_timer_unit u_wakeup_timer_unit (
      .i_clk                 (i_clk),
      .i_arst_n              (i_arst_n),
      .i_reg_addr            (i_reg_addr),
      .i_reg_wr              (i_reg_wr),
      .i_reg_wdata           (i_reg_wdata),
      .o_reg_rdata           (o_reg_rdata),
      .i_slow_oscillator     (i_slow_oscillator),
      .i_timer3_count        (i_timer3_count),
      .i_timer3_underflow    (i_timer3_underflow),
      .i_card_detected       (i_card_detected),
      .i_detect_done         (i_detect_done),
      .o_trim_start          (o_trim_start),
      .o_card_detect_start   (o_card_detect_start),
      .o_rf_field_on         (o_rf_field_on),
      .o_timer3_start        (o_timer3_start),
      .o_wake_up             (o_wake_up),
      .o_power_down          (o_power_down),
      .o_card_irq            (o_card_irq),
      .o_wake_underflow_flag (o_wake_underflow_flag)
   );
   always #50 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      trim_n <= trim_n + int'(o_trim_start === 1'b1);
      wake_n <= wake_n + int'(o_wake_up === 1'b1);
      irq_n <= irq_n + int'(o_card_irq === 1'b1);
      det_n <= det_n + int'(o_card_detect_start === 1'b1);
      t3s_n <= t3s_n + int'(o_timer3_start === 1'b1);
   end
   // ==========================================================
   // tasks
   task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(logic [6:0] a, logic [7:0] d);
      @(negedge i_clk);
      i_reg_addr = a;
      i_reg_wdata = d;
      i_reg_wr = 1'b1;
      @(negedge i_clk);
      i_reg_wr = 1'b0;
      if (a == 7'h23) begin
         m_ctl = d[5:0];
         if (d[6]) m_run = d[7];
         if (d[7:6] == 2'b11) begin
            m_cnt = m_rel;
            m_pre = 0;
            m_flag = 0;
         end
      end
      if (a == 7'h24) m_rel = {d, m_rel[7:0]};
      if (a == 7'h25) m_rel = {m_rel[15:8], d};
   endtask
   task automatic rd(logic [6:0] a, logic [7:0] e, string nm);
      @(negedge i_clk);
      i_reg_addr = a;
      @(negedge i_clk);
      chk(nm, e, o_reg_rdata);
   endtask
   task automatic tick(int n);
      repeat (n) begin
         @(negedge i_clk);
         i_slow_oscillator = 1'b1;
         repeat (4) @(negedge i_clk);
         i_slow_oscillator = 1'b0;
         repeat (3) @(negedge i_clk);
         m_pre++;
         if (m_pre == dv[m_ctl % 4]) begin
            m_pre = 0;
            if (m_run != 0 && m_cnt > 0) m_cnt--;
            else if (m_run != 0) begin
               m_flag = 1;
               m_trim += m_ctl[5];
               m_wake += m_ctl[2];
               m_det += m_ctl[4];
               if (m_ctl[3] || m_ctl[4]) m_cnt = m_rel;
               else m_run = 0;
            end
         end
      end
   endtask
   task automatic cmp();
      rd(7'h26, 8'(m_cnt >> 8), "count_high");
      rd(7'h27, 8'(m_cnt), "count_low");
      rd(7'h23, {m_run[0], 1'b0, m_ctl[5:0]}, "control");
      chk("flag", 8'(m_flag), {7'h00, o_wake_underflow_flag});
      chk("trim", 8'(m_trim), 8'(trim_n));
      chk("wake", 8'(m_wake), 8'(wake_n));
      chk("det_start", 8'(m_det), 8'(det_n));
      chk("t3_start", 8'(m_det), 8'(t3s_n));
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // ==========================================================
   // sequence
   initial begin
      repeat (30000) @(posedge i_clk);
      err_count++;
      finish_test();
   end
   initial begin
      r = $urandom(32'h0018);
      repeat (20) @(negedge i_clk);
      i_arst_n = 1'b1;
      i_timer3_count = 16'($urandom);
      wr(7'h21, 8'hA5);
      rd(7'h21, i_timer3_count[15:8], "t3_high");
      rd(7'h22, i_timer3_count[7:0], "t3_low");
      rd(7'h20, 8'h00, "unmapped");
      rd(7'h25, 8'h00, "reload_low");
      cmp();
      r = $urandom;
      wr(7'h24, 8'(r));
      rd(7'h24, 8'(r), "reload_high");
      wr(7'h24, 8'h00);
      for (cs = 0; cs < 4; cs++) begin
         r = $urandom_range(3, 1);
         wr(7'h25, 8'(r));
         wr(7'h23, 8'h80 | 8'(cs));
         cmp();
         wr(7'h23, 8'hC0 | md[cs] | 8'(cs));
         wr(7'h25, 8'h07);
         tick(dv[cs]);
         cmp();
         tick(dv[cs] * r);
         cmp();
      end
      wr(7'h23, 8'h40);
      cmp();
      wr(7'h25, 8'h01);
      wr(7'h23, 8'hD4);
      for (int k = 0; k < 2; k++) begin
         tick(2);
         cmp();
         chk("field_on", 8'h01, {7'h00, o_rf_field_on});
         @(negedge i_clk);
         i_timer3_underflow = 1'b1;
         @(negedge i_clk);
         i_timer3_underflow = 1'b0;
         i_card_detected = k[0];
         i_detect_done = 1'b1;
         @(negedge i_clk);
         i_detect_done = 1'b0;
         repeat (2) @(negedge i_clk);
         chk("field_off", 8'h00, {7'h00, o_rf_field_on});
         chk("power_down", 8'(k == 0), {7'h00, o_power_down});
      end
      chk("card_irq", 8'h01, 8'(irq_n));
      finish_test();
   end
endmodule
